// file: logic/tws_pkg.sv
`default_nettype none
package tws_pkg;
	// Register indices on the plain register port
	localparam logic [1:0] REG_CONTROL     = 2'h0;
	localparam logic [1:0] REG_STATUS      = 2'h1;
	localparam logic [1:0] REG_DATA        = 2'h2;
	localparam logic [1:0] REG_OWN_ADDRESS = 2'h3;

	// Control register bit positions
	localparam int CTL_COMPLETION_FLAG   = 7;
	localparam int CTL_ACK_ENABLE        = 6;
	localparam int CTL_START_REQUEST     = 5;
	localparam int CTL_STOP_REQUEST      = 4;
	localparam int CTL_WRITE_COLLISION   = 3;
	localparam int CTL_INTERFACE_ENABLE  = 2;
	localparam int CTL_IRQ_ENABLE        = 0;

	// Own address register layout
	localparam int OWN_GENERAL_CALL_ENABLE = 0;

	// Reset values
	localparam logic [7:0] RST_CONTROL     = 8'h00;
	localparam logic [7:0] RST_OWN_ADDRESS = 8'hfe;
	localparam logic [7:0] RST_DATA        = 8'hff;

	// Status codes, prescaler bits always zero
	localparam logic [7:0] ST_OWN_WRITE        = 8'h60;
	localparam logic [7:0] ST_ARB_OWN_WRITE    = 8'h68;
	localparam logic [7:0] ST_GEN_CALL         = 8'h70;
	localparam logic [7:0] ST_ARB_GEN_CALL     = 8'h78;
	localparam logic [7:0] ST_OWN_DATA_ACK     = 8'h80;
	localparam logic [7:0] ST_OWN_DATA_NACK    = 8'h88;
	localparam logic [7:0] ST_GC_DATA_ACK      = 8'h90;
	localparam logic [7:0] ST_GC_DATA_NACK     = 8'h98;
	localparam logic [7:0] ST_NO_INFO          = 8'hf8;
	localparam logic [7:0] STATUS_CODE_MASK    = 8'hf8;
	localparam logic [6:0] GENERAL_CALL_ADDR   = 7'h00;

	// Bits in a byte on the wire
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		TWS_IDLE,
		TWS_ADDR,
		TWS_ADDR_ACK,
		TWS_DATA,
		TWS_DATA_ACK
	} tws_phase_t;
endpackage
`default_nettype wire

// file: logic/tws_slave_rx.sv
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Upper seven own-address bits are slave address
// - Address LSB enables general call $00
// - Acknowledge address only while ack_enable set
// - Write direction enters slave receive mode
// - Address plus write sets completion flag, status
// - Lost arbitration then addressed: $68 or $78
// - Cleared ack_enable refuses next data byte
// - No own-address acknowledge while ack_enable low
// - Keep monitoring; resume recognition on ack_enable
// - Asleep, still match address using bus clock; here SCL is sampled on REF_CLK, so matching needs REF_CLK running
// - Sleep match raises wake, holds clock low
// - Completion flag cleared by writing one
// - Data register undefined after sleep wake match
// - Own address write acknowledged reports $60
// - Arbitration lost, own address reports $68
// - General call acknowledged reports $70
// - Arbitration lost, general call reports $78
// - Software clears flag; next byte acked per enable
// - Status read with prescaler bits zero
// - Own-addressed data byte acknowledged reports $80
module tws_slave_rx
	import tws_pkg::*;
(
	// Clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       ARST_N,
	// Register port
	input  wire logic [1:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output var  logic [7:0] REG_RDATA,
	// Core context
	input  wire logic       SLEEP,
	input  wire logic       ARB_LOST,
	output var  logic       WAKE,
	// Two-wire bus pins
	input  wire logic       SCL_IN,
	output var  logic       SCL_OUT,
	output var  logic       SCL_OE_N,
	input  wire logic       SDA_IN,
	output var  logic       SDA_OUT,
	output var  logic       SDA_OE_N
);
	import tws_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic       scl_s1;
		logic       scl_s2;
		logic       scl_d;
		logic       sda_s1;
		logic       sda_s2;
		logic       sda_d;
		tws_phase_t phase;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic       ack_pend;
		logic       gen_call;
		logic       arb_pend;
		logic       woke;
		logic       completion_flag;
		logic       ack_enable;
		logic       start_request;
		logic       stop_request;
		logic       interface_enable;
		logic       irq_enable;
		logic [7:0] own_address;
		logic [7:0] status;
		logic [7:0] data;
		logic [7:0] rdata;
		logic       wake;
		logic       scl_hold;
		logic       sda_low;
		logic       scl_oe_n;
		logic       sda_oe_n;
	} tws_state_t;

	tws_state_t cur;
	tws_state_t next_s;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] tws_control_view(input tws_state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[CTL_COMPLETION_FLAG]  = s.completion_flag;
		v[CTL_ACK_ENABLE]       = s.ack_enable;
		v[CTL_START_REQUEST]    = s.start_request;
		v[CTL_STOP_REQUEST]     = s.stop_request;
		v[CTL_INTERFACE_ENABLE] = s.interface_enable;
		v[CTL_IRQ_ENABLE]       = s.irq_enable;
		return v;
	endfunction

	// True on the rising edge that carries the last bit of a byte
	function automatic logic tws_byte_end(input logic [3:0] cnt);
		return cnt == BITS_PER_BYTE - 4'h1;
	endfunction

	logic flag_set;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [7:0] byte_in;
	logic own_match;
	logic gc_match;

	always_comb
	begin
		scl_rise   = cur.scl_s2 && !cur.scl_d;
		scl_fall   = !cur.scl_s2 && cur.scl_d;
		start_cond = cur.scl_s2 && cur.scl_d && cur.sda_d && !cur.sda_s2;
		stop_cond  = cur.scl_s2 && cur.scl_d && !cur.sda_d && cur.sda_s2;
		byte_in    = {cur.shift[6:0], cur.sda_s2};
		// Compare on the byte still in flight so the ack decision is ready at the eighth rise
		own_match  = byte_in[7:1] == cur.own_address[7:1];
		gc_match   = byte_in[7:1] == GENERAL_CALL_ADDR
		             && cur.own_address[OWN_GENERAL_CALL_ENABLE];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_s = cur;
		next_s.wake = 1'b0;
		flag_set    = 1'b0;
		// Pin inputs are asynchronous to REF_CLK
		next_s.scl_s1 = SCL_IN;
		next_s.scl_s2 = cur.scl_s1;
		next_s.scl_d  = cur.scl_s2;
		next_s.sda_s1 = SDA_IN;
		next_s.sda_s2 = cur.sda_s1;
		next_s.sda_d  = cur.sda_s2;

		// Kept until the next acknowledged address, then reported once
		if (ARB_LOST)
			next_s.arb_pend = 1'b1;

		// Bus side
		unique case (cur.phase)
			TWS_IDLE:
			begin
				next_s.sda_low = 1'b0;
			end
			TWS_ADDR:
			begin
				if (scl_rise)
				begin
					next_s.shift   = byte_in;
					next_s.bit_cnt = cur.bit_cnt + 4'h1;
					if (tws_byte_end(cur.bit_cnt))
					begin
						next_s.bit_cnt = 4'h0;
						// Reads go to the not addressed state here: no transmit path
						if (cur.ack_enable && !byte_in[0] && (own_match || gc_match))
						begin
							next_s.phase    = TWS_ADDR_ACK;
							next_s.gen_call = !own_match && gc_match;
							if (SLEEP)
							begin
								next_s.wake = 1'b1;
								next_s.woke = 1'b1;
							end
						end
						else
							next_s.phase = TWS_IDLE;
					end
				end
			end
			TWS_ADDR_ACK, TWS_DATA_ACK:
			begin
				// First fall drives the ack bit, the second ends it and stretches
				if (scl_fall && cur.bit_cnt == 4'h0)
				begin
					next_s.bit_cnt = 4'h1;
					next_s.sda_low = cur.phase == TWS_ADDR_ACK || cur.ack_pend;
				end
				else if (scl_fall)
				begin
					next_s.bit_cnt         = 4'h0;
					next_s.sda_low         = 1'b0;
					next_s.completion_flag = 1'b1;
					flag_set               = 1'b1;
					next_s.scl_hold        = 1'b1;
					if (cur.phase == TWS_ADDR_ACK)
					begin
						next_s.phase    = TWS_DATA;
						next_s.arb_pend = 1'b0;
						if (cur.gen_call)
							next_s.status = cur.arb_pend ? ST_ARB_GEN_CALL : ST_GEN_CALL;
						else
							next_s.status = cur.arb_pend ? ST_ARB_OWN_WRITE : ST_OWN_WRITE;
					end
					else if (cur.ack_pend)
					begin
						next_s.phase  = TWS_DATA;
						next_s.status = cur.gen_call ? ST_GC_DATA_ACK : ST_OWN_DATA_ACK;
					end
					else
					begin
						next_s.phase  = TWS_IDLE;
						next_s.status = cur.gen_call ? ST_GC_DATA_NACK : ST_OWN_DATA_NACK;
					end
				end
			end
			TWS_DATA:
			begin
				if (scl_rise)
				begin
					next_s.shift   = byte_in;
					next_s.bit_cnt = cur.bit_cnt + 4'h1;
					if (tws_byte_end(cur.bit_cnt))
					begin
						next_s.bit_cnt  = 4'h0;
						next_s.phase    = TWS_DATA_ACK;
						// Acknowledge decided by the enable at the end of the byte
						next_s.ack_pend = cur.ack_enable;
						// First byte after a sleep wake is not stored
						if (!cur.woke)
							next_s.data = byte_in;
						next_s.woke = 1'b0;
					end
				end
			end
		endcase

		// Start and stop override any phase
		if (start_cond)
		begin
			next_s.phase   = TWS_ADDR;
			next_s.bit_cnt = 4'h0;
			next_s.sda_low = 1'b0;
			// A new frame forgets a sleep wake that carried no data
			next_s.woke    = 1'b0;
		end
		else if (stop_cond)
		begin
			next_s.phase   = TWS_IDLE;
			next_s.sda_low = 1'b0;
		end

		// Register side
		next_s.rdata = 8'h00;
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				REG_CONTROL:     next_s.rdata = tws_control_view(cur);
				REG_STATUS:      next_s.rdata = cur.status & STATUS_CODE_MASK;
				REG_DATA:        next_s.rdata = cur.data;
				REG_OWN_ADDRESS: next_s.rdata = cur.own_address;
			endcase
		end
		if (REG_WR)
		begin
			unique case (REG_ADDR)
				REG_CONTROL:
				begin
					next_s.ack_enable       = REG_WDATA[CTL_ACK_ENABLE];
					next_s.start_request    = REG_WDATA[CTL_START_REQUEST];
					next_s.stop_request     = REG_WDATA[CTL_STOP_REQUEST];
					next_s.interface_enable = REG_WDATA[CTL_INTERFACE_ENABLE];
					next_s.irq_enable       = REG_WDATA[CTL_IRQ_ENABLE];
					// Write one clears; a flag raised by the bus this same cycle survives
					if (REG_WDATA[CTL_COMPLETION_FLAG] && !flag_set)
						next_s.completion_flag = 1'b0;
				end
				REG_STATUS:
				begin
					// Status is read only; writes are dropped
				end
				REG_DATA:        next_s.data = REG_WDATA;
				REG_OWN_ADDRESS: next_s.own_address = REG_WDATA;
			endcase
		end

		// Release the clock once software has answered
		if (!next_s.completion_flag)
			next_s.scl_hold = 1'b0;

		if (!next_s.interface_enable)
		begin
			next_s.phase    = TWS_IDLE;
			next_s.sda_low  = 1'b0;
			next_s.scl_hold = 1'b0;
		end

		// Enables kept as registers of their own so the pins come straight from flip-flops
		next_s.scl_oe_n = !next_s.scl_hold;
		next_s.sda_oe_n = !next_s.sda_low;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			cur             <= '0;
			cur.scl_s1      <= 1'b1;
			cur.scl_s2      <= 1'b1;
			cur.scl_d       <= 1'b1;
			cur.sda_s1      <= 1'b1;
			cur.sda_s2      <= 1'b1;
			cur.sda_d       <= 1'b1;
			cur.phase       <= TWS_IDLE;
			cur.own_address <= RST_OWN_ADDRESS;
			cur.status      <= ST_NO_INFO;
			cur.data        <= RST_DATA;
			cur.scl_oe_n    <= 1'b1;
			cur.sda_oe_n    <= 1'b1;
		end
		else
			cur <= next_s;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Open drain: drive low only, enable is active low
	always_comb
	begin
		REG_RDATA = cur.rdata;
		WAKE      = cur.wake;
		SCL_OUT   = 1'b0;
		SCL_OE_N  = cur.scl_oe_n;
		SDA_OUT   = 1'b0;
		SDA_OE_N  = cur.sda_oe_n;
	end
endmodule
`default_nettype wire

// file: dv/tws_slave_rx_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tws_slave_rx_properties
	import tws_pkg::*;
(
	// Clock and reset
	input wire logic       REF_CLK,
	input wire logic       ARST_N,
	// Register port
	input wire logic [1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	// Core context
	input wire logic       SLEEP,
	input wire logic       ARB_LOST,
	input wire logic       WAKE,
	// Bus pins
	input wire logic       SCL_IN,
	input wire logic       SCL_OUT,
	input wire logic       SCL_OE_N,
	input wire logic       SDA_IN,
	input wire logic       SDA_OUT,
	input wire logic       SDA_OE_N
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	logic clr_wr;
	assign clr_wr = REG_WR && REG_ADDR == REG_CONTROL && REG_WDATA[CTL_COMPLETION_FLAG];
	// Acknowledge spans the whole high phase of the ninth bus clock
	sequence ack_held;
		!SDA_OE_N [*6];
	endsequence
	sequence stretch_on;
		SDA_OE_N && !SCL_OE_N;
	endsequence
	a_rdata_quiet: assert property (REG_RDATA != 8'h00 |-> $past(REG_RD))
		else $error("read data outside a read");
	a_status_mask: assert property ($past(REG_RD) && $past(REG_ADDR) == REG_STATUS |-> REG_RDATA[2:0] == 3'h0)
		else $error("status prescaler bits not zero");
	a_stretch_hold: assert property (!SCL_OE_N && !clr_wr |=> !SCL_OE_N)
		else $error("clock released without flag clear");
	a_stretch_free: assert property (clr_wr && !SCL_OE_N |-> ##[1:2] SCL_OE_N)
		else $error("clock not released after flag clear");
	a_wake_cause: assert property (WAKE |-> $past(SLEEP))
		else $error("wake while awake");
	a_wake_single: assert property (WAKE |=> !WAKE)
		else $error("wake longer than one cycle");
	a_pins_low: assert property (!SCL_OUT && !SDA_OUT)
		else $error("pin drives high");
	a_ack_stretch: assert property ($fell(SDA_OE_N) |-> ack_held ##[1:20] stretch_on)
		else $error("acknowledge not followed by stretch");
endmodule
`default_nettype wire

// file: dv/tws_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
	// Resolved bus levels
	input  wire logic scl,
	input  wire logic sda,
	// Open-drain drive, one releases the line
	output var  logic scl_m,
	output var  logic sda_m
);
	int timeouts;
	initial
	begin
		scl_m    = 1'b1;
		sda_m    = 1'b1;
		timeouts = 0;
	end
	// Honours a stretching slave, but never waits forever
	task automatic rise();
		scl_m = 1'b1;
		#1;
		for (int i = 0; i < 500 && scl !== 1'b1; i++)
			#40;
		if (scl !== 1'b1)
			timeouts++;
	endtask
	task automatic start();
		sda_m = 1'b1;
		rise();
		#160 sda_m = 1'b0;
		#160 scl_m = 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge bit is sampled
	task automatic send(logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--)
		begin
			#40 sda_m = (i == 0) || b[i-1];
			#120 rise();
			#159 ack = sda;
			#1 scl_m = 1'b0;
		end
	endtask
	task automatic stop();
		#40 sda_m = 1'b0;
		#120 rise();
		#160 sda_m = 1'b1;
		#160;
	endtask
endmodule
`default_nettype wire

// file: dv/tws_slave_rx_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tws_slave_rx_bench;
	import tws_pkg::*;
	logic       REF_CLK, ARST_N, REG_WR, REG_RD, SLEEP, ARB_LOST, scl_m, sda_m;
	logic [1:0] REG_ADDR;
	logic [7:0] REG_WDATA, REG_RDATA;
	logic       WAKE, SCL_OUT, SCL_OE_N, SDA_OUT, SDA_OE_N;
	wire logic  SCL_IN = scl_m & (SCL_OE_N | SCL_OUT);
	wire logic  SDA_IN = sda_m & (SDA_OE_N | SDA_OUT);
	int         err_count, n_compared, wakes;
	tws_slave_rx dut_u (.*);
	tws_master_model mst_u (.scl(SCL_IN), .sda(SDA_IN), .scl_m(scl_m), .sda_m(sda_m));
	initial
	begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK)
		if (WAKE === 1'b1)
			wakes++;
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(logic [1:0] a, logic [7:0] v);
		@(posedge REF_CLK);
		REG_ADDR  <= a;
		REG_WDATA <= v;
		REG_WR    <= 1'b1;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(logic [1:0] a, output logic [7:0] v);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		#1 v = REG_RDATA;
	endtask
	task automatic settle();
		repeat (2) @(posedge REF_CLK);
		#1;
	endtask
	task automatic reset_case();
		logic [7:0] d;
		logic [7:0] exp_v [4];
		exp_v = '{RST_CONTROL, ST_NO_INFO, RST_DATA, RST_OWN_ADDRESS};
		wr(REG_STATUS, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			rd(2'(i), d);
			check("reset value", d, exp_v[i]);
		end
	endtask
	task automatic addr_case(logic [7:0] own, abyte, ctl, logic slp, arb, ack_exp, logic [7:0] st_exp);
		logic       ack;
		logic [7:0] d;
		int         w;
		wr(REG_OWN_ADDRESS, own);
		wr(REG_CONTROL, ctl);
		w = wakes;
		@(posedge REF_CLK);
		SLEEP    <= slp;
		ARB_LOST <= arb;
		@(posedge REF_CLK);
		ARB_LOST <= 1'b0;
		mst_u.start();
		mst_u.send(abyte, ack);
		check("address ack", {7'h0, ack}, {7'h0, !ack_exp});
		repeat (6) @(posedge REF_CLK);
		rd(REG_CONTROL, d);
		check("flag", {7'h0, d[CTL_COMPLETION_FLAG]}, {7'h0, ack_exp});
		rd(REG_STATUS, d);
		if (ack_exp)
			check("status", d, st_exp);
		check("wake", 8'(wakes - w), {7'h0, slp & ack_exp});
		SLEEP <= 1'b0;
		if (ack_exp)
		begin
			wr(REG_CONTROL, 8'h44);
			settle();
			check("hold", {7'h0, SCL_OE_N}, 8'h00);
			wr(REG_CONTROL, 8'hc4);
		end
		settle();
		check("free", {7'h0, SCL_OE_N}, 8'h01);
		mst_u.stop();
	endtask
	task automatic data_case();
		logic       ack;
		logic [7:0] d;
		wr(REG_OWN_ADDRESS, 8'hb4);
		wr(REG_CONTROL, 8'h44);
		mst_u.start();
		mst_u.send(8'hb4, ack);
		repeat (6) @(posedge REF_CLK);
		wr(REG_CONTROL, 8'hc4);
		mst_u.send(8'h3c, ack);
		check("data ack", {7'h0, ack}, 8'h00);
		repeat (6) @(posedge REF_CLK);
		rd(REG_STATUS, d);
		check("status", d, ST_OWN_DATA_ACK);
		rd(REG_DATA, d);
		check("data", d, 8'h3c);
		wr(REG_CONTROL, 8'h84);
		mst_u.send(8'hc3, ack);
		check("data nack", {7'h0, ack}, 8'h01);
		repeat (6) @(posedge REF_CLK);
		rd(REG_STATUS, d);
		check("status", d, ST_OWN_DATA_NACK);
		wr(REG_CONTROL, 8'hc4);
		mst_u.stop();
		check("stalls", 8'(mst_u.timeouts), 8'h00);
	endtask
	initial
	begin
		ARST_N    = 1'b0;
		REG_WR    = 1'b0;
		REG_RD    = 1'b0;
		REG_ADDR  = 2'h0;
		REG_WDATA = 8'h00;
		SLEEP     = 1'b0;
		ARB_LOST  = 1'b0;
		repeat (10) @(posedge REF_CLK);
		ARST_N <= 1'b1;
		reset_case();
		addr_case(8'hb4, 8'hb4, 8'h44, 0, 0, 1, ST_OWN_WRITE);
		addr_case(8'hb4, 8'hb4, 8'h44, 0, 1, 1, ST_ARB_OWN_WRITE);
		addr_case(8'hb5, 8'h00, 8'h44, 0, 0, 1, ST_GEN_CALL);
		addr_case(8'hb5, 8'h00, 8'h44, 0, 1, 1, ST_ARB_GEN_CALL);
		addr_case(8'hb4, 8'h00, 8'h44, 0, 0, 0, ST_NO_INFO);
		addr_case(8'hb4, 8'hb6, 8'h44, 0, 0, 0, ST_NO_INFO);
		addr_case(8'hb4, 8'hb5, 8'h44, 0, 0, 0, ST_NO_INFO);
		addr_case(8'hb4, 8'hb4, 8'h04, 0, 0, 0, ST_NO_INFO);
		addr_case(8'hb4, 8'hb4, 8'h40, 0, 0, 0, ST_NO_INFO);
		addr_case(8'hb4, 8'hb4, 8'h44, 1, 0, 1, ST_OWN_WRITE);
		data_case();
		print_verdict();
	end
endmodule
bind tws_slave_rx tws_slave_rx_properties chk_u (.*);
`default_nettype wire
